// ### logic/pafs_defs.vh
/*
 shared constants of the port alternate-function selector: pin counts,
 pin positions, selection field patterns and reset levels.
 assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PAFS_DEFS_VH
`define PAFS_DEFS_VH

// pin counts handled by the selector
`define PAFS_P0_WIDTH 8
`define PAFS_P1_WIDTH 5

// port 0 pin positions
`define PAFS_P0_EXTERNAL_INTERRUPT_1 0
`define PAFS_P0_SEG19 1
`define PAFS_P0_CAL1 2
`define PAFS_P0_CAL2 3
`define PAFS_P0_MOSI 4
`define PAFS_P0_MISO 5
`define PAFS_P0_SCLK 6
`define PAFS_P0_SS 7

// port 1 pin positions
`define PAFS_P1_RXD 0
`define PAFS_P1_TXD 1
`define PAFS_P1_SEG25 2
`define PAFS_P1_SEG24 3
`define PAFS_P1_SEG23 4

// interrupt pin program field patterns (X01 and 11X)
`define PAFS_INTPRG_WIDTH 3
`define PAFS_BATT_MASK 3'h3
`define PAFS_BATT_VALUE 3'h1
`define PAFS_WAKE_MASK 3'h6
`define PAFS_WAKE_VALUE 3'h6

// receive pin program field value for edge wake-up
`define PAFS_RXPRG_WIDTH 2
`define PAFS_RXPRG_WAKE 2'h3

// levels after reset
`define PAFS_IDLE_LEVEL 1'b1
`define PAFS_PIN_OUT_RESET 1'b0
`define PAFS_PIN_OE_RESET 1'b0
`define PAFS_CLAIM_RESET 1'b0

`endif

// ### logic/pafs_txd_claim.v
/*
 sticky flag that hands the transmit pin to the first uart once software
 has written its transmit buffer.
 assumes the write strobe is a one-cycle pulse synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "pafs_defs.vh"

module pafs_txd_claim (
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // transmit buffer write strobe
   input wire buffer_write_i,
   // pin claimed by the uart
   output reg claim_o
);

   reg claim_next;

   always @* begin
      claim_next = claim_o | buffer_write_i;
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         claim_o <= `PAFS_CLAIM_RESET;
      end else begin
         claim_o <= claim_next;
      end
   end

endmodule // pafs_txd_claim

// ### logic/pafs_pad_cell.v
/*
 registered output stage for a group of pins: picks the alternate drive
 or the port latch drive and samples the pin level for the port read.
 assumes pin inputs synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "pafs_defs.vh"

module pafs_pad_cell #(
   parameter W = 8
) (
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // selection and alternate drive
   input wire [W-1:0] alt_sel_i,
   input wire [W-1:0] alt_out_i,
   input wire [W-1:0] alt_oe_i,
   // port latch and pin
   input wire [W-1:0] latch_i,
   input wire [W-1:0] pin_i,
   // pin drive and read-back
   output reg [W-1:0] pin_o,
   output reg [W-1:0] pin_oe_o,
   output reg [W-1:0] read_o
);

   reg [W-1:0] pin_out_next;
   reg [W-1:0] pin_oe_next;
   integer k;

   always @* begin
      pin_out_next = {W{`PAFS_PIN_OUT_RESET}};
      pin_oe_next = {W{`PAFS_PIN_OE_RESET}};
      for (k = 0; k < W; k = k + 1) begin
         if (alt_sel_i[k]) begin
            // a cleared latch pulls the pin low over the alternate drive
            pin_out_next[k] = alt_out_i[k] & latch_i[k];
            pin_oe_next[k] = alt_oe_i[k] | ~latch_i[k];
         end else begin
            // quasi-bidirectional general purpose pin
            pin_out_next[k] = 1'b0;
            pin_oe_next[k] = ~latch_i[k];
         end
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_o <= {W{`PAFS_PIN_OUT_RESET}};
         pin_oe_o <= {W{`PAFS_PIN_OE_RESET}};
         read_o <= {W{`PAFS_IDLE_LEVEL}};
      end else begin
         pin_o <= pin_out_next;
         pin_oe_o <= pin_oe_next;
         read_o <= pin_i;
      end
   end

endmodule // pafs_pad_cell

// ### logic/pafs_port_alt_mux.v
/*
 alternate-function selector for port 0 pins 0..7 and port 1 pins 0..4.
 routes each pin to a peripheral function or leaves it as port i/o.
 assumes the enable bits come from peripheral registers elsewhere, all
 inputs synchronous to clk_i, and pins resolved outside from out/oe.
*/
`timescale 1ns/1ns
`include "pafs_defs.vh"

module pafs_port_alt_mux #(
   parameter P0_W = `PAFS_P0_WIDTH,
   parameter P1_W = `PAFS_P1_WIDTH
) (
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // port 0 enable bits
   input wire [`PAFS_INTPRG_WIDTH-1:0] interrupt_pin_program_field_i,
   input wire interrupt_1_enable_bit_i,
   input wire segment_19_enable_i,
   input wire calibration_pulse_1_disable_i,
   input wire calibration_pulse_2_disable_i,
   input wire serial_port_select_bit_i,
   input wire spi_enable_bit_i,
   input wire i2c_enable_bit_i,
   input wire zero_cross_2_enable_i,
   input wire timer_0_counter_select_i,
   input wire spi_slave_select_enable_i,
   input wire spi_master_select_bit_i,
   input wire timer_1_counter_select_i,
   input wire second_uart_receive_enable_i,
   input wire [`PAFS_RXPRG_WIDTH-1:0] receive_pin_program_field_i,
   // port 1 enable bits
   input wire first_uart_receive_enable_i,
   input wire first_uart_transmit_buffer_write_i,
   input wire segment_25_enable_i,
   input wire segment_24_enable_i,
   input wire segment_23_enable_i,
   input wire zero_cross_1_enable_i,
   input wire timer_2_external_enable_i,
   input wire timer_2_counter_select_i,
   // peripheral drive toward the pins
   input wire segment_19_drive_i,
   input wire calibration_pulse_1_i,
   input wire calibration_pulse_2_i,
   input wire spi_mosi_out_i,
   input wire spi_miso_out_i,
   input wire spi_sclk_out_i,
   input wire spi_slave_select_out_i,
   input wire i2c_sda_out_i,
   input wire i2c_scl_out_i,
   input wire zero_cross_2_i,
   input wire first_uart_txd_i,
   input wire segment_25_drive_i,
   input wire segment_24_drive_i,
   input wire segment_23_drive_i,
   input wire zero_cross_1_i,
   // port latches
   input wire [P0_W-1:0] port0_latch_i,
   input wire [P1_W-1:0] port1_latch_i,
   // pins
   input wire [P0_W-1:0] port0_pin_i,
   output wire [P0_W-1:0] port0_pin_o,
   output wire [P0_W-1:0] port0_pin_oe_o,
   input wire [P1_W-1:0] port1_pin_i,
   output wire [P1_W-1:0] port1_pin_o,
   output wire [P1_W-1:0] port1_pin_oe_o,
   // port read-back
   output wire [P0_W-1:0] port0_read_o,
   output wire [P1_W-1:0] port1_read_o,
   // pin levels toward the peripherals
   output reg battery_control_input_o,
   output reg external_interrupt_1_o,
   output reg external_interrupt_1_wake_o,
   output reg spi_mosi_in_o,
   output reg spi_miso_in_o,
   output reg spi_sclk_in_o,
   output reg spi_slave_select_in_o,
   output reg i2c_sda_in_o,
   output reg i2c_scl_in_o,
   output reg timer_0_count_input_o,
   output reg timer_1_count_input_o,
   output reg second_uart_receive_input_o,
   output reg second_uart_wake_o,
   output reg first_uart_receive_input_o,
   output reg timer_2_external_control_o,
   output reg timer_2_count_input_o,
   // transmit pin ownership
   output wire first_uart_txd_claim_o
);

   // pattern match on a masked field
   function field_match;
      input [`PAFS_INTPRG_WIDTH-1:0] field;
      input [`PAFS_INTPRG_WIDTH-1:0] mask;
      input [`PAFS_INTPRG_WIDTH-1:0] value;
      begin
         field_match = ((field & mask) == value);
      end
   endfunction

   // function enables
   wire batt_on;
   wire external_interrupt_1_on;
   wire external_interrupt_1_wake_on;
   wire spi_on;
   wire i2c_on;
   wire sclk_spi_on;
   wire sclk_i2c_on;
   wire ss_out_on;
   wire ss_in_on;
   wire second_uart_receive_input_wake_on;
   wire txd_claim;

   // alternate drive vectors
   reg [P0_W-1:0] p0_sel;
   reg [P0_W-1:0] p0_out;
   reg [P0_W-1:0] p0_oe;
   reg [P1_W-1:0] p1_sel;
   reg [P1_W-1:0] p1_out;
   reg [P1_W-1:0] p1_oe;

   // previous pin levels for wake-up edges
   reg external_interrupt_1_prev_reg;
   reg second_uart_receive_input_prev_reg;

   assign batt_on = field_match(interrupt_pin_program_field_i,
      `PAFS_BATT_MASK, `PAFS_BATT_VALUE);
   assign external_interrupt_1_on = interrupt_1_enable_bit_i;
   assign external_interrupt_1_wake_on = field_match(interrupt_pin_program_field_i,
      `PAFS_WAKE_MASK, `PAFS_WAKE_VALUE);
   assign spi_on = serial_port_select_bit_i & spi_enable_bit_i;
   assign i2c_on = ~serial_port_select_bit_i & i2c_enable_bit_i;
   // spi takes the clock unless only i2c is routed to the serial pins
   assign sclk_spi_on = spi_enable_bit_i & (serial_port_select_bit_i | ~i2c_enable_bit_i);
   assign sclk_i2c_on = i2c_enable_bit_i & ~sclk_spi_on;
   assign ss_out_on = spi_master_select_bit_i;
   assign ss_in_on = spi_slave_select_enable_i & ~spi_master_select_bit_i;
   assign second_uart_receive_input_wake_on = (receive_pin_program_field_i == `PAFS_RXPRG_WAKE);

   // port 0 alternate selection
   always @* begin
      p0_sel = {P0_W{1'b0}};
      p0_out = {P0_W{1'b0}};
      p0_oe = {P0_W{1'b0}};
      // input-only functions on p0.0
      p0_sel[`PAFS_P0_EXTERNAL_INTERRUPT_1] = batt_on | external_interrupt_1_on | external_interrupt_1_wake_on;
      if (segment_19_enable_i) begin
         p0_sel[`PAFS_P0_SEG19] = 1'b1;
         p0_out[`PAFS_P0_SEG19] = segment_19_drive_i;
         p0_oe[`PAFS_P0_SEG19] = 1'b1;
      end
      if (!calibration_pulse_1_disable_i) begin
         p0_sel[`PAFS_P0_CAL1] = 1'b1;
         p0_out[`PAFS_P0_CAL1] = calibration_pulse_1_i;
         p0_oe[`PAFS_P0_CAL1] = 1'b1;
      end
      if (!calibration_pulse_2_disable_i) begin
         p0_sel[`PAFS_P0_CAL2] = 1'b1;
         p0_out[`PAFS_P0_CAL2] = calibration_pulse_2_i;
         p0_oe[`PAFS_P0_CAL2] = 1'b1;
      end
      if (spi_on) begin
         p0_sel[`PAFS_P0_MOSI] = 1'b1;
         p0_out[`PAFS_P0_MOSI] = spi_mosi_out_i;
         p0_oe[`PAFS_P0_MOSI] = spi_master_select_bit_i;
      end else if (i2c_on) begin
         // open drain: only a low level is driven
         p0_sel[`PAFS_P0_MOSI] = 1'b1;
         p0_oe[`PAFS_P0_MOSI] = ~i2c_sda_out_i;
      end
      if (spi_on) begin
         p0_sel[`PAFS_P0_MISO] = 1'b1;
         p0_out[`PAFS_P0_MISO] = spi_miso_out_i;
         p0_oe[`PAFS_P0_MISO] = ~spi_master_select_bit_i;
      end else if (zero_cross_2_enable_i) begin
         p0_sel[`PAFS_P0_MISO] = 1'b1;
         p0_out[`PAFS_P0_MISO] = zero_cross_2_i;
         p0_oe[`PAFS_P0_MISO] = 1'b1;
      end
      if (sclk_spi_on) begin
         p0_sel[`PAFS_P0_SCLK] = 1'b1;
         p0_out[`PAFS_P0_SCLK] = spi_sclk_out_i;
         p0_oe[`PAFS_P0_SCLK] = spi_master_select_bit_i;
      end else if (sclk_i2c_on) begin
         p0_sel[`PAFS_P0_SCLK] = 1'b1;
         p0_oe[`PAFS_P0_SCLK] = ~i2c_scl_out_i;
      end else if (timer_0_counter_select_i) begin
         p0_sel[`PAFS_P0_SCLK] = 1'b1;
      end
      if (ss_out_on) begin
         p0_sel[`PAFS_P0_SS] = 1'b1;
         p0_out[`PAFS_P0_SS] = spi_slave_select_out_i;
         p0_oe[`PAFS_P0_SS] = 1'b1;
      end else begin
         p0_sel[`PAFS_P0_SS] = ss_in_on | timer_1_counter_select_i
            | second_uart_receive_enable_i | second_uart_receive_input_wake_on;
      end
   end

   // port 1 alternate selection
   always @* begin
      p1_sel = {P1_W{1'b0}};
      p1_out = {P1_W{1'b0}};
      p1_oe = {P1_W{1'b0}};
      p1_sel[`PAFS_P1_RXD] = first_uart_receive_enable_i;
      if (txd_claim) begin
         p1_sel[`PAFS_P1_TXD] = 1'b1;
         p1_out[`PAFS_P1_TXD] = first_uart_txd_i;
         p1_oe[`PAFS_P1_TXD] = 1'b1;
      end
      if (segment_25_enable_i) begin
         p1_sel[`PAFS_P1_SEG25] = 1'b1;
         p1_out[`PAFS_P1_SEG25] = segment_25_drive_i;
         p1_oe[`PAFS_P1_SEG25] = 1'b1;
      end else if (zero_cross_1_enable_i) begin
         p1_sel[`PAFS_P1_SEG25] = 1'b1;
         p1_out[`PAFS_P1_SEG25] = zero_cross_1_i;
         p1_oe[`PAFS_P1_SEG25] = 1'b1;
      end
      if (segment_24_enable_i) begin
         p1_sel[`PAFS_P1_SEG24] = 1'b1;
         p1_out[`PAFS_P1_SEG24] = segment_24_drive_i;
         p1_oe[`PAFS_P1_SEG24] = 1'b1;
      end else begin
         p1_sel[`PAFS_P1_SEG24] = timer_2_external_enable_i;
      end
      if (segment_23_enable_i) begin
         p1_sel[`PAFS_P1_SEG23] = 1'b1;
         p1_out[`PAFS_P1_SEG23] = segment_23_drive_i;
         p1_oe[`PAFS_P1_SEG23] = 1'b1;
      end else begin
         p1_sel[`PAFS_P1_SEG23] = timer_2_counter_select_i;
      end
   end

   // pin levels toward the peripherals, idle high when not routed; wake pulses idle low
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         battery_control_input_o <= `PAFS_IDLE_LEVEL;
         external_interrupt_1_o <= `PAFS_IDLE_LEVEL;
         external_interrupt_1_wake_o <= 1'b0;
         spi_mosi_in_o <= `PAFS_IDLE_LEVEL;
         spi_miso_in_o <= `PAFS_IDLE_LEVEL;
         spi_sclk_in_o <= `PAFS_IDLE_LEVEL;
         spi_slave_select_in_o <= `PAFS_IDLE_LEVEL;
         i2c_sda_in_o <= `PAFS_IDLE_LEVEL;
         i2c_scl_in_o <= `PAFS_IDLE_LEVEL;
         timer_0_count_input_o <= `PAFS_IDLE_LEVEL;
         timer_1_count_input_o <= `PAFS_IDLE_LEVEL;
         second_uart_receive_input_o <= `PAFS_IDLE_LEVEL;
         second_uart_wake_o <= 1'b0;
         first_uart_receive_input_o <= `PAFS_IDLE_LEVEL;
         timer_2_external_control_o <= `PAFS_IDLE_LEVEL;
         timer_2_count_input_o <= `PAFS_IDLE_LEVEL;
         external_interrupt_1_prev_reg <= `PAFS_IDLE_LEVEL;
         second_uart_receive_input_prev_reg <= `PAFS_IDLE_LEVEL;
      end else begin
         battery_control_input_o <= batt_on ? port0_pin_i[`PAFS_P0_EXTERNAL_INTERRUPT_1] : 1'b1;
         external_interrupt_1_o <= external_interrupt_1_on ? port0_pin_i[`PAFS_P0_EXTERNAL_INTERRUPT_1] : 1'b1;
         // falling edge on the interrupt pin
         external_interrupt_1_wake_o <= external_interrupt_1_wake_on & external_interrupt_1_prev_reg & ~port0_pin_i[`PAFS_P0_EXTERNAL_INTERRUPT_1];
         spi_mosi_in_o <= spi_on ? port0_pin_i[`PAFS_P0_MOSI] : 1'b1;
         spi_miso_in_o <= spi_on ? port0_pin_i[`PAFS_P0_MISO] : 1'b1;
         spi_sclk_in_o <= sclk_spi_on ? port0_pin_i[`PAFS_P0_SCLK] : 1'b1;
         spi_slave_select_in_o <= ss_in_on ? port0_pin_i[`PAFS_P0_SS] : 1'b1;
         i2c_sda_in_o <= i2c_on ? port0_pin_i[`PAFS_P0_MOSI] : 1'b1;
         i2c_scl_in_o <= sclk_i2c_on ? port0_pin_i[`PAFS_P0_SCLK] : 1'b1;
         timer_0_count_input_o <= timer_0_counter_select_i ?
            port0_pin_i[`PAFS_P0_SCLK] : 1'b1;
         timer_1_count_input_o <= timer_1_counter_select_i ?
            port0_pin_i[`PAFS_P0_SS] : 1'b1;
         second_uart_receive_input_o <= second_uart_receive_enable_i ?
            port0_pin_i[`PAFS_P0_SS] : 1'b1;
         // either edge on the second uart receive pin
         second_uart_wake_o <= second_uart_receive_input_wake_on & (second_uart_receive_input_prev_reg ^ port0_pin_i[`PAFS_P0_SS]);
         first_uart_receive_input_o <= first_uart_receive_enable_i ?
            port1_pin_i[`PAFS_P1_RXD] : 1'b1;
         timer_2_external_control_o <= timer_2_external_enable_i ?
            port1_pin_i[`PAFS_P1_SEG24] : 1'b1;
         timer_2_count_input_o <= timer_2_counter_select_i ?
            port1_pin_i[`PAFS_P1_SEG23] : 1'b1;
         external_interrupt_1_prev_reg <= port0_pin_i[`PAFS_P0_EXTERNAL_INTERRUPT_1];
         second_uart_receive_input_prev_reg <= port0_pin_i[`PAFS_P0_SS];
      end
   end

   // transmit pin ownership
   pafs_txd_claim u_txd_claim (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .buffer_write_i(first_uart_transmit_buffer_write_i),
      .claim_o(txd_claim)
   );

   assign first_uart_txd_claim_o = txd_claim;

   // port 0 output stage
   pafs_pad_cell #(
      .W(P0_W)
   ) u_port0_pads (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .alt_sel_i(p0_sel),
      .alt_out_i(p0_out),
      .alt_oe_i(p0_oe),
      .latch_i(port0_latch_i),
      .pin_i(port0_pin_i),
      .pin_o(port0_pin_o),
      .pin_oe_o(port0_pin_oe_o),
      .read_o(port0_read_o)
   );

   // port 1 output stage
   pafs_pad_cell #(
      .W(P1_W)
   ) u_port1_pads (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .alt_sel_i(p1_sel),
      .alt_out_i(p1_out),
      .alt_oe_i(p1_oe),
      .latch_i(port1_latch_i),
      .pin_i(port1_pin_i),
      .pin_o(port1_pin_o),
      .pin_oe_o(port1_pin_oe_o),
      .read_o(port1_read_o)
   );

endmodule // pafs_port_alt_mux

// ### bench/pafs_board_model.sv
/*
 board circuitry on the selector's pins: resolves each pin level.
 assumes weak pull-ups on every pin and board drive only where enabled.
*/
`timescale 1ns/1ns

module pafs_board_model #(
   parameter W = 13
) (
   // device side
   input wire [W-1:0] pin_i,
   input wire [W-1:0] pin_oe_i,
   // board drive
   input wire [W-1:0] ext_i,
   input wire [W-1:0] ext_en_i,
   // resolved level
   output wire [W-1:0] level_o
);
   // device drive first, then board drive, else pull-up
   assign level_o = (pin_oe_i & pin_i) | (~pin_oe_i & ((ext_en_i & ext_i) | ~ext_en_i));
endmodule // pafs_board_model

// ### bench/pafs_port_alt_mux_checker.sv
/*
 concurrent checks on the selector's ports.
 assumes one clock domain with an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`include "pafs_defs.vh"

module pafs_port_alt_mux_checker #(
   parameter P0_W = 8,
   parameter P1_W = 5
) (
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // enables and drives
   input wire [`PAFS_INTPRG_WIDTH-1:0] interrupt_pin_program_field_i,
   input wire interrupt_1_enable_bit_i,
   input wire spi_slave_select_enable_i,
   input wire spi_master_select_bit_i,
   input wire segment_19_enable_i,
   input wire segment_19_drive_i,
   input wire calibration_pulse_1_disable_i,
   input wire calibration_pulse_1_i,
   input wire first_uart_transmit_buffer_write_i,
   input wire first_uart_txd_i,
   input wire [P0_W-1:0] port0_latch_i,
   input wire [P1_W-1:0] port1_latch_i,
   // pins
   input wire [P0_W-1:0] port0_pin_i,
   input wire [P0_W-1:0] port0_pin_o,
   input wire [P0_W-1:0] port0_pin_oe_o,
   input wire [P0_W-1:0] port0_read_o,
   input wire [P1_W-1:0] port1_pin_o,
   input wire [P1_W-1:0] port1_pin_oe_o,
   // peripheral side
   input wire battery_control_input_o,
   input wire external_interrupt_1_o,
   input wire external_interrupt_1_wake_o,
   input wire spi_slave_select_in_o,
   input wire first_uart_txd_claim_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_seg19_drive: assert property (segment_19_enable_i && port0_latch_i[1] |=>
      port0_pin_oe_o[1] && port0_pin_o[1] == $past(segment_19_drive_i)) else $error("seg drive");
   chk_cal_pulse_drive: assert property (!calibration_pulse_1_disable_i && port0_latch_i[2]
      |=> port0_pin_oe_o[2] && port0_pin_o[2] == $past(calibration_pulse_1_i))
      else $error("pulse drive");
   chk_gpio_idle: assert property (!segment_19_enable_i |=> !port0_pin_o[1] &&
      port0_pin_oe_o[1] == !$past(port0_latch_i[1])) else $error("idle pin");
   chk_irq_route: assert property (1'b1 |=> external_interrupt_1_o ==
      ($past(interrupt_1_enable_bit_i) ? $past(port0_pin_i[0]) : 1'b1)) else $error("irq tap");
   chk_battery_route: assert property (interrupt_pin_program_field_i[1:0] == 2'h1 |=>
      battery_control_input_o == $past(port0_pin_i[0])) else $error("battery tap");
   chk_wake_edge: assert property ($fell(port0_pin_i[0]) &&
      interrupt_pin_program_field_i[2:1] == 2'h3 |=> external_interrupt_1_wake_o) else $error("wake pulse");
   chk_txd_claim: assert property (first_uart_transmit_buffer_write_i |=>
      first_uart_txd_claim_o [*3]) else $error("claim lost");
   chk_txd_drive: assert property (first_uart_txd_claim_o && port1_latch_i[1] |=>
      port1_pin_oe_o[1] && port1_pin_o[1] == $past(first_uart_txd_i)) else $error("tx pin");

   chk_ss_route: assert property (spi_slave_select_enable_i
      && !spi_master_select_bit_i |=> spi_slave_select_in_o == $past(port0_pin_i[7]))
      else $error("ss tap");
   chk_read_back: assert property (1'b1 |=> port0_read_o == $past(port0_pin_i))
      else $error("read back");

   cover property (external_interrupt_1_wake_o);
   cover property ($rose(first_uart_txd_claim_o));
   cover property (calibration_pulse_1_disable_i ##1 !calibration_pulse_1_disable_i);
endmodule // pafs_port_alt_mux_checker

bind pafs_port_alt_mux pafs_port_alt_mux_checker #(.P0_W(P0_W), .P1_W(P1_W))
   i_pafs_port_alt_mux_checker (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .interrupt_pin_program_field_i(interrupt_pin_program_field_i),
   .interrupt_1_enable_bit_i(interrupt_1_enable_bit_i),
   .spi_slave_select_enable_i(spi_slave_select_enable_i),
   .spi_master_select_bit_i(spi_master_select_bit_i), .port0_read_o(port0_read_o),
   .spi_slave_select_in_o(spi_slave_select_in_o),
   .segment_19_enable_i(segment_19_enable_i), .segment_19_drive_i(segment_19_drive_i),
   .calibration_pulse_1_disable_i(calibration_pulse_1_disable_i),
   .calibration_pulse_1_i(calibration_pulse_1_i), .first_uart_txd_i(first_uart_txd_i),
   .first_uart_transmit_buffer_write_i(first_uart_transmit_buffer_write_i),
   .port0_latch_i(port0_latch_i), .port1_latch_i(port1_latch_i), .port0_pin_i(port0_pin_i),
   .port0_pin_o(port0_pin_o), .port0_pin_oe_o(port0_pin_oe_o), .port1_pin_o(port1_pin_o),
   .port1_pin_oe_o(port1_pin_oe_o), .battery_control_input_o(battery_control_input_o),
   .external_interrupt_1_o(external_interrupt_1_o), .external_interrupt_1_wake_o(external_interrupt_1_wake_o),
   .first_uart_txd_claim_o(first_uart_txd_claim_o));

// ### bench/pafs_port_alt_mux_tb.sv
/*
 self-checking bench of the pin selector with a board model on its pins.
 assumes registered outputs one cycle after their inputs.
*/
`timescale 1ns/1ns
`define CHK(o, e) begin n_tests++; if ((o) !== (e)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, (o), (e)); end end

module pafs_port_alt_mux_tb;
   localparam logic [36:0] ALL = 37'h1FFFFFFFFF;
   logic clk_i, arst_n_i, wr, spi;
   logic [2:0] ipf;
   logic [1:0] rpf;
   logic [19:0] en;
   logic [14:0] drv;
   logic [12:0] lat, ext, xen, eo, ex, pv;
   logic [10:0] te;
   logic [31:0] r;
   wire [12:0] pin, po, oe;
   wire [10:0] tp;
   wire [36:0] obs = {tp, oe[12:8], po[12:8], oe[7:0], po[7:0]};
   int cyc = 0, n_fail = 0, n_tests = 0, i;
   int qd[$];
   logic [36:0] qm[$], qe[$];

   pafs_port_alt_mux i_pafs_port_alt_mux (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .interrupt_pin_program_field_i(ipf), .interrupt_1_enable_bit_i(en[0]),
      .segment_19_enable_i(en[1]), .calibration_pulse_1_disable_i(en[2]),
      .calibration_pulse_2_disable_i(en[3]), .serial_port_select_bit_i(en[4]),
      .spi_enable_bit_i(en[5]), .i2c_enable_bit_i(en[6]), .zero_cross_2_enable_i(en[7]),
      .timer_0_counter_select_i(en[8]), .spi_slave_select_enable_i(en[9]),
      .spi_master_select_bit_i(en[10]), .timer_1_counter_select_i(en[11]),
      .second_uart_receive_enable_i(en[12]), .receive_pin_program_field_i(rpf),
      .first_uart_receive_enable_i(en[13]), .first_uart_transmit_buffer_write_i(wr),
      .segment_25_enable_i(en[14]), .segment_24_enable_i(en[15]),
      .segment_23_enable_i(en[16]), .zero_cross_1_enable_i(en[17]),
      .timer_2_external_enable_i(en[18]), .timer_2_counter_select_i(en[19]),
      .segment_19_drive_i(drv[0]), .calibration_pulse_1_i(drv[1]),
      .calibration_pulse_2_i(drv[2]), .spi_mosi_out_i(drv[3]), .spi_miso_out_i(drv[4]),
      .spi_sclk_out_i(drv[5]), .spi_slave_select_out_i(drv[6]), .i2c_sda_out_i(drv[7]),
      .i2c_scl_out_i(drv[8]), .zero_cross_2_i(drv[9]), .first_uart_txd_i(drv[10]),
      .segment_25_drive_i(drv[11]), .segment_24_drive_i(drv[12]),
      .segment_23_drive_i(drv[13]), .zero_cross_1_i(drv[14]),
      .port0_latch_i(lat[7:0]), .port1_latch_i(lat[12:8]), .port0_pin_i(pin[7:0]),
      .port0_pin_o(po[7:0]), .port0_pin_oe_o(oe[7:0]), .port1_pin_i(pin[12:8]),
      .port1_pin_o(po[12:8]), .port1_pin_oe_o(oe[12:8]), .port0_read_o(), .port1_read_o(),
      .battery_control_input_o(tp[0]), .external_interrupt_1_o(tp[1]), .external_interrupt_1_wake_o(tp[2]),
      .spi_mosi_in_o(), .spi_miso_in_o(), .spi_sclk_in_o(), .spi_slave_select_in_o(),
      .i2c_sda_in_o(), .i2c_scl_in_o(), .timer_0_count_input_o(tp[6]),
      .timer_1_count_input_o(tp[7]), .second_uart_receive_input_o(tp[8]),
      .second_uart_wake_o(tp[9]), .first_uart_receive_input_o(tp[3]),
      .timer_2_external_control_o(tp[4]), .timer_2_count_input_o(tp[5]),
      .first_uart_txd_claim_o(tp[10]));

   pafs_board_model i_pafs_board_model (.pin_i(po), .pin_oe_i(oe), .ext_i(ext),
      .ext_en_i(xen), .level_o(pin));

   function logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function logic [36:0] pk(input logic [10:0] t, input logic [12:0] o, input logic [12:0] d);
      pk = {t, o[12:8], d[12:8], o[7:0], d[7:0]};
   endfunction

   task tick;
      @(posedge clk_i);
      #1;
   endtask

   task note(input logic [36:0] m, input logic [36:0] e);
      qd.push_back(cyc + 1);
      qm.push_back(m);
      qe.push_back(e);
   endtask

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         n_fail++;
         end_of_test;
      end
   end

   always @(negedge clk_i) begin
      if (qd.size() > 0 && qd[0] == cyc) begin
         `CHK(obs & qm[0], qe[0] & qm[0])
         qd.pop_front();
         qm.pop_front();
         qe.pop_front();
      end
   end

   initial begin
      r = 32'hA1592443;
      arst_n_i = 1'b0; ipf = 3'h0; rpf = 2'h0; en = 20'h0000C; drv = 15'h0000; wr = 1'b0;
      lat = 13'h1FFF; ext = 13'h0000; xen = 13'h0000;
      note(ALL, pk(11'h1FB, 13'h0000, 13'h0000));
      tick;
      tick;
      arst_n_i = 1'b1;
      for (i = 0; i < 8; i++) begin
         tick;
         r = lfsr(r);
         lat = r[12:0];
         note(ALL, pk(11'h1FB, ~lat, 13'h0000));
      end
      $display("test idle pins done");
      tick;
      lat = 13'h1FFF;
      for (i = 0; i < 32; i++) begin
         tick;
         r = lfsr(r);
         en = r[19:0] & 20'h3C4FE;
         r = lfsr(r);
         drv = r[14:0];
         eo = 13'h0000;
         ex = 13'h0000;
         spi = en[4] & en[5];
         if (en[1]) {eo[1], ex[1]} = {1'b1, drv[0]};
         if (!en[2]) {eo[2], ex[2]} = {1'b1, drv[1]};
         if (!en[3]) {eo[3], ex[3]} = {1'b1, drv[2]};
         if (spi) {eo[4], ex[4], eo[5], ex[5]} = {en[10], drv[3], !en[10], drv[4]};
         else if (en[6]) {eo[4], ex[4]} = {!drv[7], 1'b0};
         if (!spi && en[7]) {eo[5], ex[5]} = {1'b1, drv[9]};
         if (en[5] && (en[4] || !en[6])) {eo[6], ex[6]} = {en[10], drv[5]};
         else if (en[6]) {eo[6], ex[6]} = {!drv[8], 1'b0};
         if (en[10]) {eo[7], ex[7]} = {1'b1, drv[6]};
         if (en[14]) {eo[10], ex[10]} = {1'b1, drv[11]};
         else if (en[17]) {eo[10], ex[10]} = {1'b1, drv[14]};
         if (en[15]) {eo[11], ex[11]} = {1'b1, drv[12]};
         if (en[16]) {eo[12], ex[12]} = {1'b1, drv[13]};
         note(pk(11'h7FF, 13'h1FFF, eo), pk(11'h1FB, eo, ex));
      end
      $display("test pin drive done");
      tick;
      en = 20'h0000C;
      xen = 13'h1FFF;
      ext = 13'h1FFF;
      pv = 13'h1FFF;
      tick;
      for (i = 0; i < 40; i++) begin
         tick;
         r = lfsr(r);
         en = (r[19:0] & 20'hC3B01) | 20'h0000C;
         ipf = r[22:20];
         rpf = r[24:23];
         r = lfsr(r);
         ext = r[12:0];
         te[0] = ipf[1:0] == 2'h1 ? ext[0] : 1'b1;
         te[1] = en[0] ? ext[0] : 1'b1;
         te[2] = ipf[2:1] == 2'h3 && pv[0] && !ext[0];
         te[3] = en[13] ? ext[8] : 1'b1;
         te[4] = en[18] ? ext[11] : 1'b1;
         te[5] = en[19] ? ext[12] : 1'b1;
         te[6] = en[8] ? ext[6] : 1'b1;
         te[7] = en[11] ? ext[7] : 1'b1;
         te[8] = en[12] ? ext[7] : 1'b1;
         te[9] = rpf == 2'h3 && pv[7] != ext[7];
         te[10] = 1'b0;
         note(ALL, pk(te, 13'h0000, 13'h0000));
         pv = ext;
      end
      $display("test input taps done");
      tick;
      ipf = 3'h0; rpf = 2'h0; xen = 13'h0000; wr = 1'b1;
      note(pk(11'h400, 13'h0000, 13'h0000), pk(11'h400, 13'h0000, 13'h0000));
      for (i = 0; i < 3; i++) begin
         tick;
         wr = 1'b0;
         r = lfsr(r);
         drv = r[14:0];
         note(pk(11'h400, 13'h0200, 13'h0200), pk(11'h400, 13'h0200, {3'h0, drv[10], 9'h000}));
      end
      tick;
      tick;
      arst_n_i = 1'b0;
      note(ALL, pk(11'h1FB, 13'h0000, 13'h0000));
      tick;
      tick;
      arst_n_i = 1'b1;
      $display("test transmit claim done");
      tick;
      tick;
      end_of_test;
   end
endmodule // pafs_port_alt_mux_tb
